/* include/ppq_pkg.sv */
// Shared constants and types of the pace pulse qualifier
package ppq_pkg;
  // Register bus address width in bits
  localparam int AXI_AW = 6;

  // Register indices; byte offset is four times the index
  localparam int IDX_CTRL     = 0;
  localparam int IDX_AMP      = 1;
  localparam int IDX_RT_MIN   = 2;
  localparam int IDX_RT_MAX   = 3;
  localparam int IDX_DUR_MIN  = 4;
  localparam int IDX_DUR_MAX  = 5;
  localparam int IDX_HOLD     = 6;
  localparam int IDX_STATUS   = 7;
  localparam int IDX_MEAS_AMP = 8;
  localparam int IDX_MEAS_RT  = 9;
  localparam int IDX_MEAS_DUR = 10;
  localparam int CFG_N        = 7;

  // Control field positions
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_CLR_BIT  = 1;
  localparam int CTRL_AUTO_BIT = 2;
  localparam logic [31:0] CTRL_MASK = 32'h0000_0005;

  // Status field positions
  localparam int STAT_FLAG_BIT  = 0;
  localparam int STAT_STATE_LSB = 4;

  // Reset values: control bits, then amplitude codes or clock cycles
  localparam logic [31:0] CFG_RST [CFG_N] = '{
    32'h0000_0001,
    32'h0000_0010,
    32'h0000_0004,
    32'h0000_0040,
    32'h0000_0008,
    32'h0000_0400,
    32'h0000_0100
  };

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_RISE = 4'h2,
    ST_DUR  = 4'h4,
    ST_FLAG = 4'h8
  } ppq_state_t;
endpackage

/* logic/ppq_span_meter.sv */
// Saturating cycle meter with inclusive window compare
`timescale 1ns/1ps
`default_nettype none
module ppq_span_meter
  import ppq_pkg::*;
#(
  parameter int W = 18
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         reset,
  // Control
  input  wire logic         clear,
  input  wire logic         run,
  // Window bounds, inclusive
  input  wire logic [W-1:0] win_lo,
  input  wire logic [W-1:0] win_hi,
  // Result
  output logic [W-1:0]      count,
  output logic              in_window
);
  if (W < 2 || W > 32) begin : g_chk
    $error("ppq_span_meter: W out of range");
  end

  // Saturate so a stuck input cannot wrap back into the window
  always_ff @(posedge mclk) begin
    if (reset || clear) begin
      count <= '0;
    end else if (run && count != '1) begin
      count <= count + 1'b1;
    end
  end

  assign in_window = (count >= win_lo) && (count <= win_hi);
endmodule
`default_nettype wire

/* logic/ppq_top.sv */
// Pace pulse qualifier: sequencer, meters and register slave
// Contract
// - Pulse goes on only when its amplitude exceeds the amplitude threshold.
// - A failed amplitude check abandons the pulse and waits for the next.
// - Rise time is measured with amplitude and checked against a window.
// - Rise time outside the window: no duration measurement, wait again.
// - Duration measurement starts only when amplitude and rise time pass; here u_dur counts from pulse start.
// - After both checks pass, duration is measured and window-checked.
// - Duration inside its window raises the pace detect flag.
// - After detection, host or internal reset restarts the search.
// - Duration outside its window: no flag, wait for another pulse.
// - The result reaches the host as one digital output level.
// - Host configures and reads back the device as bus master.
//
// The AXI4-Lite register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ppq_top
  import ppq_pkg::*;
#(
  parameter int AMP_W = 12,
  parameter int CNT_W = 18
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              reset,
  // Conditioned pulse from the analog front
  input  wire logic              pulse_present,
  input  wire logic              pulse_peak,
  input  wire logic [AMP_W-1:0]  amp_value,
  // Host connector lines
  input  wire logic              host_reset,
  output logic                   pace_pulse,
  // AXI4-Lite write channels
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);
  if (AMP_W < 1 || AMP_W > 32 || CNT_W < 2 || CNT_W > 32) begin : g_chk
    $error("ppq_top: unsupported width");
  end

  localparam logic [31:0] AMP_MASK = 32'((64'h1 << AMP_W) - 64'h1);
  localparam logic [31:0] CNT_MASK = 32'((64'h1 << CNT_W) - 64'h1);

  ppq_state_t        state;
  ppq_state_t        next_state;
  logic [31:0]       cfg [CFG_N];
  logic [AXI_AW-1:0] aw_addr_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;
  logic [3:0]        wr_idx;
  logic [3:0]        rd_idx;
  logic              wr_go;
  logic [31:0]       rd_word;
  logic              sw_clear;
  logic              pulse_prev;
  logic              start_evt;
  logic [AMP_W-1:0]  peak_q;
  logic [AMP_W-1:0]  next_peak;
  logic              amp_ok;
  logic              rt_ok;
  logic              dur_ok;
  logic              hold_done;
  logic              det_evt;
  logic              clr_evt;
  logic [CNT_W-1:0]  rise_count;
  logic [CNT_W-1:0]  dur_count;
  logic [AMP_W-1:0]  meas_amp;
  logic [CNT_W-1:0]  meas_rt;
  logic [CNT_W-1:0]  meas_dur;

  // Register bus write side
  // bus target
  assign wr_idx = aw_addr_q[5:2];
  assign wr_go  = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      aw_addr_q     <= '0;
      w_data_q      <= 32'h0;
      w_strb_q      <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr_q     <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_idx <= 4'(IDX_MEAS_DUR)) ? RESP_OKAY
                                                     : RESP_DECERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Writable registers; read-only ones ignore writes
  for (genvar i = 0; i < CFG_N; i++) begin : g_cfg
    localparam logic [31:0] MASK = (i == IDX_CTRL) ? CTRL_MASK :
                                   (i == IDX_AMP)  ? AMP_MASK : CNT_MASK;
    always_ff @(posedge mclk) begin
      if (reset) begin
        cfg[i] <= CFG_RST[i];
      end else if (wr_go && wr_idx == 4'(i)) begin
        for (int b = 0; b < 4; b++) begin
          if (w_strb_q[b]) begin
            cfg[i][8*b +: 8] <= w_data_q[8*b +: 8] & MASK[8*b +: 8];
          end
        end
      end
    end
  end

  // Clear bit acts on write and is never stored
  assign sw_clear = wr_go && wr_idx == 4'(IDX_CTRL) && w_strb_q[0]
                    && w_data_q[CTRL_CLR_BIT];

  // Register bus read side
  assign rd_idx = s_axi_araddr[5:2];

  always_comb begin
    rd_word = 32'h0;
    if (rd_idx < 4'(CFG_N)) begin
      rd_word = cfg[3'(rd_idx)];
    end else if (rd_idx == 4'(IDX_STATUS)) begin
      rd_word[STAT_FLAG_BIT] = pace_pulse;
      rd_word[STAT_STATE_LSB +: 4] = state;
    end else if (rd_idx == 4'(IDX_MEAS_AMP)) begin
      rd_word[AMP_W-1:0] = meas_amp;
    end else if (rd_idx == 4'(IDX_MEAS_RT)) begin
      rd_word[CNT_W-1:0] = meas_rt;
    end else if (rd_idx == 4'(IDX_MEAS_DUR)) begin
      rd_word[CNT_W-1:0] = meas_dur;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= (rd_idx <= 4'(IDX_MEAS_DUR)) ? RESP_OKAY
                                                    : RESP_DECERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Only a fresh rising edge starts an attempt, never a pulse tail
  always_ff @(posedge mclk) begin
    if (reset) begin
      pulse_prev <= 1'b0;
    end else begin
      pulse_prev <= pulse_present;
    end
  end
  assign start_evt = pulse_present && !pulse_prev;

  assign next_peak = (amp_value > peak_q) ? amp_value : peak_q;
  assign amp_ok    = next_peak > cfg[IDX_AMP][AMP_W-1:0];

  always_ff @(posedge mclk) begin
    if (reset || state != ST_RISE) begin
      peak_q <= '0;
    end else begin
      peak_q <= next_peak;
    end
  end

  ppq_span_meter #(.W(CNT_W)) u_rise (
    .mclk      (mclk),
    .reset     (reset),
    .clear     (state == ST_IDLE),
    .run       (state == ST_RISE),
    .win_lo    (cfg[IDX_RT_MIN][CNT_W-1:0]),
    .win_hi    (cfg[IDX_RT_MAX][CNT_W-1:0]),
    .count     (rise_count),
    .in_window (rt_ok)
  );

  ppq_span_meter #(.W(CNT_W)) u_dur (
    .mclk      (mclk),
    .reset     (reset),
    .clear     (state == ST_IDLE),
    .run       (state == ST_RISE || state == ST_DUR),
    .win_lo    (cfg[IDX_DUR_MIN][CNT_W-1:0]),
    .win_hi    (cfg[IDX_DUR_MAX][CNT_W-1:0]),
    .count     (dur_count),
    .in_window (dur_ok)
  );

  // Internal reset source: flag hold timer
  ppq_span_meter #(.W(CNT_W)) u_hold (
    .mclk      (mclk),
    .reset     (reset),
    .clear     (state != ST_FLAG),
    .run       (state == ST_FLAG),
    .win_lo    (cfg[IDX_HOLD][CNT_W-1:0]),
    .win_hi    (CNT_W'(CNT_MASK)),
    .count     (),
    .in_window (hold_done)
  );

  assign det_evt = state == ST_DUR && !pulse_present && dur_ok;
  assign clr_evt = host_reset || sw_clear
                   || (cfg[IDX_CTRL][CTRL_AUTO_BIT] && hold_done);

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (cfg[IDX_CTRL][CTRL_EN_BIT] && start_evt) begin
          next_state = ST_RISE;
        end
      end
      ST_RISE: begin
        if (!pulse_present) begin
          next_state = ST_IDLE;
        end else if (pulse_peak) begin
          next_state = (amp_ok && rt_ok) ? ST_DUR : ST_IDLE;
        end
      end
      ST_DUR: begin
        if (!pulse_present) begin
          next_state = dur_ok ? ST_FLAG : ST_IDLE;
        end
      end
      ST_FLAG: begin
        next_state = ST_FLAG;
      end
    endcase
    if (clr_evt && !det_evt) begin
      next_state = ST_IDLE;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // flag pin mirrors the flagged state
  always_ff @(posedge mclk) begin
    if (reset) begin
      pace_pulse <= 1'b0;
    end else begin
      pace_pulse <= next_state == ST_FLAG;
    end
  end

  // Last measurements, kept for readback
  always_ff @(posedge mclk) begin
    if (reset) begin
      meas_amp <= '0;
      meas_rt  <= '0;
      meas_dur <= '0;
    end else begin
      if (state == ST_RISE && pulse_present && pulse_peak) begin
        meas_amp <= next_peak;
        meas_rt  <= rise_count;
      end
      if (state == ST_DUR && !pulse_present) begin
        meas_dur <= dur_count;
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence peak_s;
    state == ST_RISE && pulse_present && pulse_peak;
  endsequence

  sequence detect_s;
    state == ST_DUR && !pulse_present && dur_ok;
  endsequence

  sequence write_pair_s;
    !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  endsequence

  amp_reject_a: assert property (
    peak_s and !amp_ok |=> state == ST_IDLE && !pace_pulse)
    else $error("amplitude failure did not return to idle");

  rise_reject_a: assert property (
    peak_s and !rt_ok |=> state == ST_IDLE ##1 state != ST_DUR)
    else $error("rise window failure started duration");

  dur_gate_a: assert property (
    $rose(state == ST_DUR) |-> $past(amp_ok) && $past(rt_ok))
    else $error("duration started without both checks");

  rise_count_a: assert property (
    state == ST_RISE && rise_count != CNT_W'(CNT_MASK)
    |=> rise_count == $past(rise_count) + 1'b1)
    else $error("rise meter not counting during rise check");

  flag_set_a: assert property (
    detect_s |=> pace_pulse && state == ST_FLAG)
    else $error("valid duration did not raise the flag");

  dur_reject_a: assert property (
    state == ST_DUR && !pulse_present && !dur_ok
    |=> !pace_pulse [*2])
    else $error("flag raised on bad duration");

  flag_hold_a: assert property (
    pace_pulse && !clr_evt |=> pace_pulse && state == ST_FLAG)
    else $error("flag dropped without a reset");

  host_clear_a: assert property (
    host_reset && !det_evt |=> !pace_pulse && state == ST_IDLE)
    else $error("host reset did not clear the detector");

  seq_shape_a: assert property (
    $onehot(state) && (pace_pulse == (state == ST_FLAG)))
    else $error("sequencer state illegal or flag mismatched");

  bus_write_a: assert property (
    write_pair_s |=> s_axi_bvalid [*1] ##0 s_axi_awready == 1'b0)
    else $error("write response missing after address and data");
endmodule
`default_nettype wire

/* verif/ppq_host_model.sv */
// Host model: watches the pace flag and clears it through the reset line
`timescale 1ns/1ps
`default_nettype none
module ppq_host_model (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       reset,
  // Connector lines
  input  wire logic       pace_pulse,
  output logic            host_reset,
  // Bench control: clear request and reaction delay
  input  wire logic       clr_req,
  input  wire logic [3:0] lag
);
  logic [3:0] wait_cnt;

  always_ff @(posedge mclk) begin
    host_reset <= 1'b0;
    if (reset || !(clr_req && pace_pulse)) begin
      wait_cnt <= 4'h0;
    end else if (wait_cnt == lag) begin
      host_reset <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

/* verif/pace_pulse_qualifier_tb.sv */
// Self-checking bench of the pace pulse qualifier
`timescale 1ns/1ps
`default_nettype none
module pace_pulse_qualifier_tb;
  import ppq_pkg::*;
  logic        mclk = 0;
  logic        reset = 1;
  logic        present = 0, peak = 0, clr_req = 0;
  logic [11:0] amp = 0;
  logic [3:0]  lag = 0;
  logic        host_reset, pace_pulse;
  logic [5:0]  awaddr = 0, araddr = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rdata, rd, seed = 1;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] th [CFG_N];
  int          fails = 0, n_compared = 0, cycles = 0;
  int          corn [12][3] = '{'{16, 5, 20}, '{17, 5, 20}, '{17, 3, 20},
    '{17, 4, 20}, '{17, 64, 80}, '{17, 65, 80}, '{17, 4, 7}, '{17, 4, 8},
    '{17, 4, 1024}, '{17, 4, 1025}, '{17, 10, 6}, '{40, 2, 1000}};

  ppq_top uut (
    .mclk(mclk), .reset(reset), .pulse_present(present),
    .pulse_peak(peak), .amp_value(amp), .host_reset(host_reset),
    .pace_pulse(pace_pulse), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready)
  );

  ppq_host_model host (
    .mclk(mclk), .reset(reset), .pace_pulse(pace_pulse),
    .host_reset(host_reset), .clr_req(clr_req), .lag(lag)
  );

  initial begin
    forever #5 mclk = ~mclk;
  end

  // Ceiling well above the longest pulse mix
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      fails++;
      wrap_up();
    end
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input string name, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wr(input int idx, input logic [31:0] d);
    bit done;
    done = 0;
    @(posedge mclk);
    awaddr <= 6'(idx * 4);
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!done) begin
      @(posedge mclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid) begin
        done = 1;
        resp = bresp;
        bready <= 0;
      end
    end
  endtask

  task automatic rd_reg(input int idx);
    bit done;
    done = 0;
    @(posedge mclk);
    araddr <= 6'(idx * 4);
    arvalid <= 1;
    rready <= 1;
    while (!done) begin
      @(posedge mclk);
      if (arready) arvalid <= 0;
      if (rvalid) begin
        done = 1;
        rd = rdata;
        resp = rresp;
        rready <= 0;
      end
    end
  endtask

  function automatic logic exp_flag(logic [11:0] a, int rt, int d);
    return a > th[1] && rt >= th[2] && rt <= th[3] && rt < d
      && d >= th[4] && d <= th[5];
  endfunction

  // Peak at rise count rt, falling edge seen at duration count d
  task automatic pulse(input logic [11:0] a, input int rt, input int d);
    @(posedge mclk);
    present <= 1;
    amp <= a;
    for (int i = 1; i <= d + 1; i++) begin
      @(posedge mclk);
      peak <= (i == rt + 1);
      present <= (i <= d);
    end
    @(posedge mclk);
    peak <= 0;
    amp <= 12'(xs());
    @(posedge mclk);
    #1;
  endtask

  task automatic clear(input int how);
    if (how == 0) begin
      clr_req <= 1;
      lag <= 4'(xs());
      for (int k = 0; k < 40 && pace_pulse; k++) @(posedge mclk);
      clr_req <= 0;
    end else
      wr(IDX_CTRL, 32'h3);
    @(posedge mclk);
    #1;
    check("flag cleared", pace_pulse, 0);
    rd_reg(IDX_STATUS);
    check("status idle", rd, 32'h10);
  endtask

  task automatic try_one(input logic [11:0] a, input int rt, d, how);
    logic e;
    e = exp_flag(a, rt, d);
    pulse(a, rt, d);
    check("pace_pulse", pace_pulse, e);
    if (e) begin
      rd_reg(IDX_MEAS_AMP);
      check("meas amp", rd, 32'(a));
      rd_reg(IDX_MEAS_RT);
      check("meas rise", rd, rt);
      rd_reg(IDX_MEAS_DUR);
      check("meas dur", rd, d);
      rd_reg(IDX_STATUS);
      check("status flag", rd, 32'h81);
      clear(how);
    end
  endtask

  initial begin
    repeat (10) @(posedge mclk);
    reset <= 0;
    check("flag after reset", pace_pulse, 0);
    check("ready after reset", {awready, wready, arready, bvalid, rvalid},
          5'h1C);
    for (int i = 0; i < CFG_N; i++) begin
      rd_reg(i);
      check("reset value", rd, CFG_RST[i]);
      th[i] = CFG_RST[i];
    end
    rd_reg(11);
    check("unmapped", resp, RESP_DECERR);
    wr(11, 32'h1);
    check("unmapped write", resp, RESP_DECERR);
    wr(IDX_STATUS, 32'hFFFF);
    check("ro write", resp, RESP_OKAY);
    rd_reg(IDX_STATUS);
    check("ro kept", rd, 32'h10);
    wr(IDX_AMP, 32'hFFFF_FFFF);
    rd_reg(IDX_AMP);
    check("amp width", rd, 32'hFFF);
    wr(IDX_AMP, th[1]);
    for (int i = 0; i < 12; i++)
      try_one(12'(corn[i][0]), corn[i][1], corn[i][2], i % 2);
    for (int i = 0; i < 24; i++) begin
      int rt;
      rt = xs() % 72;
      try_one(12'(xs() % 32), rt, rt + 1 + xs() % 1040, i % 2);
    end
    // Disabled sequencer ignores a good pulse
    wr(IDX_CTRL, 32'h0);
    pulse(17, 5, 20);
    check("disabled", pace_pulse, 0);
    wr(IDX_CTRL, 32'h1);
    // Flag holds and later pulses are ignored while flagged
    pulse(17, 5, 20);
    repeat (30) @(posedge mclk);
    #1;
    check("flag held", pace_pulse, 1);
    pulse(17, 6, 30);
    rd_reg(IDX_MEAS_DUR);
    check("flagged ignore", rd, 20);
    clear(1);
    // Internal auto clear after the hold time
    wr(IDX_HOLD, 32'h10);
    wr(IDX_CTRL, 32'h5);
    pulse(17, 5, 20);
    repeat (8) @(posedge mclk);
    #1;
    check("auto hold", pace_pulse, 1);
    repeat (16) @(posedge mclk);
    #1;
    check("auto clear", pace_pulse, 0);
    // Mid-run reset drops the flag and restores the settings
    pulse(17, 5, 20);
    check("flag before reset", pace_pulse, 1);
    @(posedge mclk);
    reset <= 1;
    @(posedge mclk);
    reset <= 0;
    @(posedge mclk);
    #1;
    check("flag by reset", pace_pulse, 0);
    rd_reg(IDX_STATUS);
    check("state by reset", rd, 32'h10);
    rd_reg(IDX_HOLD);
    check("hold by reset", rd, CFG_RST[IDX_HOLD]);
    rd_reg(IDX_CTRL);
    check("ctrl by reset", rd, CFG_RST[IDX_CTRL]);
    wrap_up();
  end
endmodule
`default_nettype wire
